// [hw/wdpcg_map.svh]
// timing constants and default values for the watchdog and chip-enable gate
// assumes a 200 MHz reference clock; included by bare name
`ifndef WDPCG_MAP_SVH
`define WDPCG_MAP_SVH

`define WDPCG_CLK_MHZ          200
`define WDPCG_PULSE_US         1000
`define WDPCG_PULSE_CYC        (`WDPCG_PULSE_US * `WDPCG_CLK_MHZ)
`define WDPCG_LAG_NS           70
`define WDPCG_LAG_CYC          ((`WDPCG_LAG_NS * `WDPCG_CLK_MHZ + 999) / 1000)
`define WDPCG_CE_HOLD_US       15
`define WDPCG_CE_HOLD_CYC      (`WDPCG_CE_HOLD_US * `WDPCG_CLK_MHZ)
`define WDPCG_STROBE_MIN_NS    100
`define WDPCG_STROBE_MIN_CYC   ((`WDPCG_STROBE_MIN_NS * `WDPCG_CLK_MHZ + 999) / 1000)
`define WDPCG_DEF_TIMEOUT_MS   1600
`define WDPCG_DEF_TIMEOUT_CYC  (`WDPCG_DEF_TIMEOUT_MS * `WDPCG_CLK_MHZ * 1000)
`define WDPCG_MS_PER_NF_X10    21
`define WDPCG_CAP_MIN_NF_X10   47
`define WDPCG_CAP_MAX_NF_X10   1000
`define WDPCG_CAP_DEF_NF_X10   100
`define WDPCG_CNT_W            32

`endif

// [hw/wdpcg_pkg.sv]
// types shared by the watchdog and chip-enable gate modules
// assumes wdpcg_map.svh for all figures
package wdpcg_pkg;

  // --------------------------------------------------------------
  // watchdog sequencer states
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    WDPCG_IDLE,
    WDPCG_ARMED,
    WDPCG_PULSE,
    WDPCG_FAULT
  } wdpcg_wd_state_type;

  // --------------------------------------------------------------
  // chip-enable gate states
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    WDPCG_CE_OFF,
    WDPCG_CE_PASS,
    WDPCG_CE_DRAIN
  } wdpcg_ce_state_type;

  // fault outputs travel together
  typedef struct packed {
    logic pulse_n;
    logic level_n;
  } wdpcg_fault_type;

endpackage : wdpcg_pkg

// [hw/wdpcg_down_counter.sv]
// loadable down counter with a zero flag
// assumes the caller holds load for one cycle to start a count
`timescale 1ns/1ps
`default_nettype none
module wdpcg_down_counter #(
  parameter int W = 32
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         run,
  output var  logic         at_zero
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // --------------------------------------------------------------
  // next count: load wins, then count down while running
  // --------------------------------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (run && (cnt_ff != '0)) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign at_zero = (cnt_ff == '0);

endmodule : wdpcg_down_counter
`default_nettype wire

// [hw/wdpcg_strobe_detect.sv]
// detects a sampled level change on the watchdog strobe; a pulse is caught by its edges
// assumes the strobe is already synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module wdpcg_strobe_detect #(
  parameter int MIN_CYC = 20
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic strobe,
  output var  logic kick
);

  logic       last_ff;
  logic       nxt_last;

  // --------------------------------------------------------------
  // any edge restarts the timer; a pulse always holds two edges so a
  // pulse of MIN_CYC or more is covered by the edge term as well
  // --------------------------------------------------------------
  always_comb begin
    nxt_last = strobe;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_ff <= 1'b0;
    end else begin
      last_ff <= nxt_last;
    end
  end

  assign kick = (strobe != last_ff);

endmodule : wdpcg_strobe_detect
`default_nettype wire

// [hw/wdpcg_top.sv]
// watchdog with early fault pulse, level fault, and chip-enable gating
// assumes all inputs synchronous to ref_clk; rst comes from the supply monitor
// Notes on behaviour
// - missed strobe by timeout end drives fault pulse low for 1 ms
// - level fault falls 70 ns after the pulse falls
// - still no strobe next period: level stays low, another pulse issued
// - strobe transition after fault returns level fault high
// - timeout select tied high picks the 1.6 s default
// - capacitor select gives 2.1 ms per nF, valid 4.7 to 100 nF
// - in normal operation chip select passes through as a registered copy, one clock behind
// - while reset is asserted chip select input is ignored once the path has closed
// - on power-down path closes at chip select high or 15 us
// - on power-up path stays closed until reset deasserts
// - closed path drives chip select output high, released when open
// - timer restarts on any strobe edge or pulse of 100 ns
// - reset, battery backup or floating strobe disable watchdog, level high
`timescale 1ns/1ps
`default_nettype none
`include "wdpcg_map.svh"

module wdpcg_top #(
  parameter int unsigned PULSE_CYC   = `WDPCG_PULSE_CYC,
  parameter int unsigned CE_HOLD_CYC = `WDPCG_CE_HOLD_CYC,
  parameter int unsigned DEF_TO_CYC  = `WDPCG_DEF_TIMEOUT_CYC,
  parameter int unsigned CAP_NF_X10  = `WDPCG_CAP_DEF_NF_X10
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic watchdog_strobe_in,
  input  wire logic strobe_floating,
  input  wire logic battery_backup,
  input  wire logic timeout_select_in,
  input  wire logic chip_sel_in_n,
  output var  logic watchdog_fault_pulse_n,
  output var  logic watchdog_fault_level_n,
  output var  logic chip_sel_out_n,
  output var  logic chip_sel_drive_high
);

  localparam int unsigned W = `WDPCG_CNT_W;
  localparam int unsigned LAG_CYC = `WDPCG_LAG_CYC;
  // clamp the capacitor into the valid span before scaling
  localparam int unsigned CAP_USE =
    (CAP_NF_X10 < `WDPCG_CAP_MIN_NF_X10) ? `WDPCG_CAP_MIN_NF_X10 :
    (CAP_NF_X10 > `WDPCG_CAP_MAX_NF_X10) ? `WDPCG_CAP_MAX_NF_X10 : CAP_NF_X10;
  localparam longint unsigned CAP_TO_CYC =
    (64'(`WDPCG_MS_PER_NF_X10) * 64'(CAP_USE) * 64'(`WDPCG_CLK_MHZ) * 64'd1000) / 64'd100;

  // --------------------------------------------------------------
  // strobe edge detection
  // --------------------------------------------------------------
  // a sampled change is the only kick; a strobe pulse narrower than one
  // clock period can be missed, so the processor must hold it for 100 ns
  logic kick;

  wdpcg_strobe_detect #(
    .MIN_CYC (`WDPCG_STROBE_MIN_CYC)
  ) u_detect (
    .ref_clk (ref_clk),
    .rst     (rst),
    .strobe  (watchdog_strobe_in),
    .kick    (kick)
  );

  // --------------------------------------------------------------
  // timeout selection
  // --------------------------------------------------------------
  logic [W-1:0] timeout_cyc;

  // tied high picks the internal default, else the capacitor figure
  // the capacitor figure is fixed at build time; the pin only chooses
  // between the two counts, and the choice is taken at every reload
  always_comb begin
    if (timeout_select_in) begin
      timeout_cyc = W'(DEF_TO_CYC);
    end else begin
      timeout_cyc = W'(CAP_TO_CYC);
    end
  end

  // --------------------------------------------------------------
  // watchdog sequencer
  // --------------------------------------------------------------
  wdpcg_pkg::wdpcg_wd_state_type wd_state_ff;
  wdpcg_pkg::wdpcg_wd_state_type nxt_wd_state;
  wdpcg_pkg::wdpcg_fault_type    fault_ff;
  wdpcg_pkg::wdpcg_fault_type    nxt_fault;
  logic [7:0]                    lag_ff;
  logic [7:0]                    nxt_lag;
  logic                          lag_pend_ff;
  logic                          nxt_lag_pend;
  logic                          to_load;
  logic                          to_zero;
  logic                          pl_load;
  logic                          pl_zero;
  logic                          wd_off;

  // floating and battery arrive as plain flags; their detection is analog
  assign wd_off = rst || battery_backup || strobe_floating;

  wdpcg_down_counter #(
    .W (W)
  ) u_timeout (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .load     (to_load),
    .load_val (timeout_cyc),
    .run      (1'b1),
    .at_zero  (to_zero)
  );

  wdpcg_down_counter #(
    .W (W)
  ) u_pulse (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .load     (pl_load),
    .load_val (W'(PULSE_CYC)),
    .run      (1'b1),
    .at_zero  (pl_zero)
  );

  // next state of the watchdog; a strobe always restarts the period
  always_comb begin
    nxt_wd_state = wd_state_ff;
    nxt_fault    = fault_ff;
    nxt_lag      = lag_ff;
    nxt_lag_pend = lag_pend_ff;
    to_load      = 1'b0;
    pl_load      = 1'b0;
    if (lag_pend_ff) begin
      // level follows the pulse after the fixed lag
      if (lag_ff <= 8'h01) begin
        nxt_fault.level_n = 1'b0;
        nxt_lag_pend      = 1'b0;
      end else begin
        nxt_lag = lag_ff - 8'h01;
      end
    end
    unique case (wd_state_ff)
      // one cycle to load the period after the watchdog comes back on
      wdpcg_pkg::WDPCG_IDLE: begin
        to_load      = 1'b1;
        nxt_wd_state = wdpcg_pkg::WDPCG_ARMED;
      end
      wdpcg_pkg::WDPCG_ARMED, wdpcg_pkg::WDPCG_FAULT: begin
        if (kick) begin
          to_load           = 1'b1;
          nxt_fault.level_n = 1'b1;
          nxt_lag_pend      = 1'b0;
          nxt_wd_state      = wdpcg_pkg::WDPCG_ARMED;
        end else if (to_zero) begin
          // timeout: start pulse; level lags unless already low
          pl_load           = 1'b1;
          to_load           = 1'b1;
          nxt_fault.pulse_n = 1'b0;
          if (fault_ff.level_n) begin
            nxt_lag_pend = 1'b1;
            nxt_lag      = 8'(LAG_CYC);
          end
          nxt_wd_state = wdpcg_pkg::WDPCG_PULSE;
        end
      end
      wdpcg_pkg::WDPCG_PULSE: begin
        if (kick) begin
          to_load           = 1'b1;
          nxt_fault.level_n = 1'b1;
          nxt_lag_pend      = 1'b0;
        end
        if (pl_zero && !pl_load) begin
          nxt_fault.pulse_n = 1'b1;
          nxt_wd_state = nxt_fault.level_n ? wdpcg_pkg::WDPCG_ARMED
                                           : wdpcg_pkg::WDPCG_FAULT;
        end
      end
      default: begin
        nxt_wd_state = wdpcg_pkg::WDPCG_IDLE;
      end
    endcase
    if (wd_off) begin
      // disabled watchdog holds both fault outputs high
      nxt_wd_state = wdpcg_pkg::WDPCG_IDLE;
      nxt_fault    = '{pulse_n: 1'b1, level_n: 1'b1};
      nxt_lag_pend = 1'b0;
      to_load      = 1'b0;
      pl_load      = 1'b0;
    end
  end

  // pulse counter is one cycle stale right after load; guarded above
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wd_state_ff <= wdpcg_pkg::WDPCG_IDLE;
      fault_ff    <= '{pulse_n: 1'b1, level_n: 1'b1};
      lag_ff      <= 8'h00;
      lag_pend_ff <= 1'b0;
    end else begin
      wd_state_ff <= nxt_wd_state;
      fault_ff    <= nxt_fault;
      lag_ff      <= nxt_lag;
      lag_pend_ff <= nxt_lag_pend;
    end
  end

  // --------------------------------------------------------------
  // watchdog outputs
  // --------------------------------------------------------------
  // both fault pins leave one register group, so the lag stays exact
  assign watchdog_fault_pulse_n = fault_ff.pulse_n;
  assign watchdog_fault_level_n = fault_ff.level_n;

  // --------------------------------------------------------------
  // chip-enable gate
  // --------------------------------------------------------------
  wdpcg_pkg::wdpcg_ce_state_type ce_state_ff;
  wdpcg_pkg::wdpcg_ce_state_type nxt_ce_state;
  logic                          ce_out_ff;
  logic                          nxt_ce_out;
  logic                          ce_drv_ff;
  logic                          nxt_ce_drv;
  logic                          hold_load;
  logic                          hold_zero;

  // hold counter has no reset on purpose: rst is what starts the drain,
  // so resetting it would kill the window that it is meant to time;
  // its zero flag is only read in the drain state, after a load
  wdpcg_down_counter #(
    .W (W)
  ) u_ce_hold (
    .ref_clk  (ref_clk),
    .rst      (1'b0),
    .load     (hold_load),
    .load_val (W'(CE_HOLD_CYC)),
    .run      (1'b1),
    .at_zero  (hold_zero)
  );

  // gate is a registered copy, one cycle behind the input
  always_comb begin
    nxt_ce_state = ce_state_ff;
    nxt_ce_out   = 1'b1;
    nxt_ce_drv   = 1'b1;
    hold_load    = 1'b0;
    unique case (ce_state_ff)
      wdpcg_pkg::WDPCG_CE_OFF: begin
        // stays closed until reset drops, input ignored
        if (!rst) begin
          nxt_ce_state = wdpcg_pkg::WDPCG_CE_PASS;
        end
      end
      wdpcg_pkg::WDPCG_CE_PASS: begin
        if (rst) begin
          if (!chip_sel_in_n) begin
            // an access in flight may finish
            hold_load    = 1'b1;
            nxt_ce_out   = 1'b0;
            nxt_ce_drv   = 1'b0;
            nxt_ce_state = wdpcg_pkg::WDPCG_CE_DRAIN;
          end else begin
            nxt_ce_state = wdpcg_pkg::WDPCG_CE_OFF;
          end
        end else begin
          nxt_ce_out = chip_sel_in_n;
          nxt_ce_drv = 1'b0;
        end
      end
      wdpcg_pkg::WDPCG_CE_DRAIN: begin
        if (chip_sel_in_n || (hold_zero && !hold_load)) begin
          nxt_ce_state = wdpcg_pkg::WDPCG_CE_OFF;
        end else begin
          nxt_ce_out = 1'b0;
          nxt_ce_drv = 1'b0;
        end
      end
      default: begin
        nxt_ce_state = wdpcg_pkg::WDPCG_CE_OFF;
      end
    endcase
  end

  // reset is also the power-down trigger, so it is seen in the next-state
  always_ff @(posedge ref_clk) begin
    if (ce_state_ff == wdpcg_pkg::WDPCG_CE_DRAIN || !rst) begin
      ce_state_ff <= nxt_ce_state;
      ce_out_ff   <= nxt_ce_out;
      ce_drv_ff   <= nxt_ce_drv;
    end else if (ce_state_ff == wdpcg_pkg::WDPCG_CE_PASS) begin
      ce_state_ff <= nxt_ce_state;
      ce_out_ff   <= nxt_ce_out;
      ce_drv_ff   <= nxt_ce_drv;
    end else begin
      ce_state_ff <= wdpcg_pkg::WDPCG_CE_OFF;
      ce_out_ff   <= 1'b1;
      ce_drv_ff   <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // chip-enable outputs
  // --------------------------------------------------------------
  // pull-up request and select leave together, never a floating gap
  assign chip_sel_out_n      = ce_out_ff;
  assign chip_sel_drive_high = ce_drv_ff;

endmodule : wdpcg_top
`default_nettype wire

// [test/wdpcg_shutdown_model.sv]
// shutdown latch outside the supervisor, clocked by the fault pulse
// assumes rst from the supply monitor clears it
`timescale 1ns/1ps
`default_nettype none
module wdpcg_shutdown_model (
  input  wire logic rst,
  input  wire logic watchdog_fault_pulse_n,
  input  wire logic watchdog_fault_level_n,
  output var  logic shutdown_n
);
  // samples the level on the pulse's falling edge, so one fault alone never latches
  always @(negedge watchdog_fault_pulse_n or posedge rst) begin
    if (rst) begin
      shutdown_n <= 1'b1;
    end else begin
      shutdown_n <= watchdog_fault_level_n;
    end
  end
endmodule : wdpcg_shutdown_model
`default_nettype wire

// [test/wdpcg_top_chk.sv]
// port checker for the watchdog and chip-enable gate
// assumes one clock; bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module wdpcg_top_chk #(
  parameter int unsigned PULSE_CYC   = 200000,
  parameter int unsigned CE_HOLD_CYC = 3000,
  parameter int unsigned DEF_TO_CYC  = 320000000,
  parameter int unsigned CAP_NF_X10  = 100
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic watchdog_strobe_in,
  input wire logic strobe_floating,
  input wire logic battery_backup,
  input wire logic timeout_select_in,
  input wire logic chip_sel_in_n,
  input wire logic watchdog_fault_pulse_n,
  input wire logic watchdog_fault_level_n,
  input wire logic chip_sel_out_n,
  input wire logic chip_sel_drive_high
);
  localparam int DRAIN_MAX = CE_HOLD_CYC + 3;
  localparam int PER_LO    = DEF_TO_CYC - 3;
  localparam int PER_HI    = DEF_TO_CYC + 5;
  int unsigned lo_cnt_ff;
  int unsigned per_ff;
  int unsigned drain_ff;
  logic        strobe_ff;
  logic        pulse_ff;
  logic        wd_on;

  default clocking cb @(posedge ref_clk); endclocking
  assign wd_on = !rst && !strobe_floating && !battery_backup;

  // pulse width and time since the last restart; slack covers pipeline stages
  always_ff @(posedge ref_clk) begin
    strobe_ff <= watchdog_strobe_in;
    pulse_ff  <= watchdog_fault_pulse_n;
    lo_cnt_ff <= watchdog_fault_pulse_n ? 0 : lo_cnt_ff + 1;
    // cycles that the select stays passed low while reset is up
    drain_ff  <= (rst && !chip_sel_out_n) ? drain_ff + 1 : 0;
    if (!wd_on || (watchdog_strobe_in != strobe_ff) || (pulse_ff && !watchdog_fault_pulse_n))
      per_ff <= 0;
    else
      per_ff <= per_ff + 1;
  end

  a_pulse_width: assert property (disable iff (rst)
    $rose(watchdog_fault_pulse_n) && $past(wd_on) |-> lo_cnt_ff inside {[PULSE_CYC:PULSE_CYC + 2]})
    else $error("fault pulse width off");
  a_level_lag: assert property (disable iff (rst)
    $fell(watchdog_fault_pulse_n) && watchdog_fault_level_n
    |-> ##13 watchdog_fault_level_n ##1 !watchdog_fault_level_n)
    else $error("level fault lag off");
  a_level_stays: assert property (disable iff (rst)
    wd_on && !watchdog_fault_level_n && $stable(watchdog_strobe_in) |=> !watchdog_fault_level_n)
    else $error("level fault dropped without strobe");
  a_kick_clears: assert property (disable iff (rst)
    wd_on && $changed(watchdog_strobe_in) |=> watchdog_fault_level_n)
    else $error("strobe did not clear level fault");
  a_timeout_period: assert property (disable iff (rst)
    $fell(watchdog_fault_pulse_n) |-> per_ff inside {[PER_LO:PER_HI]})
    else $error("timeout period off");
  a_quiet_level: assert property (
    !wd_on |=> watchdog_fault_level_n)
    else $error("level fault low while disabled");
  a_gate_follow: assert property (disable iff (rst)
    !rst [*2] |=> chip_sel_out_n == $past(chip_sel_in_n) && !chip_sel_drive_high)
    else $error("select not passed");
  a_drain_bound: assert property (
    drain_ff <= DRAIN_MAX)
    else $error("drain too long");
  a_drain_sel: assert property (
    rst && $rose(chip_sel_in_n) |=> chip_sel_out_n)
    else $error("drain did not end on select high");
  a_closed_high: assert property (
    rst && $past(rst) && chip_sel_out_n |=> chip_sel_out_n && chip_sel_drive_high)
    else $error("closed gate not held high");
  a_drive_open: assert property (
    !chip_sel_out_n |-> !chip_sel_drive_high)
    else $error("pull-up on while passing low");

  c_fault: cover property ($fell(watchdog_fault_pulse_n));
  c_second: cover property ($fell(watchdog_fault_pulse_n) && !watchdog_fault_level_n);
  c_drain: cover property ($rose(rst) && !chip_sel_in_n);
endmodule : wdpcg_top_chk

bind wdpcg_top wdpcg_top_chk #(
  .PULSE_CYC(PULSE_CYC), .CE_HOLD_CYC(CE_HOLD_CYC), .DEF_TO_CYC(DEF_TO_CYC),
  .CAP_NF_X10(CAP_NF_X10)
) wdpcg_top_chk_i (
  .ref_clk(ref_clk), .rst(rst), .watchdog_strobe_in(watchdog_strobe_in),
  .strobe_floating(strobe_floating), .battery_backup(battery_backup),
  .timeout_select_in(timeout_select_in), .chip_sel_in_n(chip_sel_in_n),
  .watchdog_fault_pulse_n(watchdog_fault_pulse_n),
  .watchdog_fault_level_n(watchdog_fault_level_n), .chip_sel_out_n(chip_sel_out_n),
  .chip_sel_drive_high(chip_sel_drive_high));
`default_nettype wire

// [test/wdpcg_top_tb.sv]
// self-checking bench for the watchdog and chip-enable gate
// assumes short counts; timeout select at the internal default but in one test
`timescale 1ns/1ps
`default_nettype none
module wdpcg_top_tb;
  localparam int PULSE = 50;
  localparam int HOLD  = 20;
  localparam int TOUT  = 200;
  logic ref_clk, rst, strobe, floating, battery, sel_in_n, tout_sel;
  logic pulse_n, level_n, sel_out_n, drive_hi, shut_n, seen;
  int   failures, cmp_count, cycles;

  wdpcg_top #(.PULSE_CYC(PULSE), .CE_HOLD_CYC(HOLD), .DEF_TO_CYC(TOUT), .CAP_NF_X10(47))
  wdpcg_top_i (.ref_clk(ref_clk), .rst(rst), .watchdog_strobe_in(strobe),
    .strobe_floating(floating), .battery_backup(battery), .timeout_select_in(tout_sel),
    .chip_sel_in_n(sel_in_n), .watchdog_fault_pulse_n(pulse_n),
    .watchdog_fault_level_n(level_n), .chip_sel_out_n(sel_out_n),
    .chip_sel_drive_high(drive_hi));
  wdpcg_shutdown_model wdpcg_shutdown_model_i (.rst(rst), .watchdog_fault_pulse_n(pulse_n),
    .watchdog_fault_level_n(level_n), .shutdown_n(shut_n));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // hang guard, and a sticky flag for any fault pulse
  always @(posedge ref_clk) begin
    cycles++;
    if (pulse_n === 1'b0) seen <= 1'b1;
    if (cycles == 6000) begin
      failures++;
      $display("FAIL %0t run hung", $time);
      report_and_stop();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic chk(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : chk

  task automatic do_reset();
    rst = 1'b1;
    cyc(6);
    rst = 1'b0;
    seen = 1'b0;
    cyc(1);
  endtask : do_reset

  // bounded wait for the pulse to fall
  task automatic wait_fall(input int lim);
    int n;
    n = 0;
    while (pulse_n !== 1'b0 && n < lim) begin
      cyc(1);
      n++;
    end
    chk(pulse_n, 1'b0, "no fault pulse");
  endtask : wait_fall

  task automatic t_gate();
    rst = 1'b1;
    cyc(3);
    sel_in_n = 1'b0;
    cyc(3);
    chk(sel_out_n, 1'b1, "select leaked in reset");
    chk(drive_hi, 1'b1, "pull-up off in reset");
    rst = 1'b0;
    cyc(3);
    chk(sel_out_n, 1'b0, "select not passed");
    chk(drive_hi, 1'b0, "pull-up left on");
    sel_in_n = 1'b1;
    cyc(1);
    chk(sel_out_n, 1'b1, "rise not passed");
    sel_in_n = 1'b0;
    cyc(1);
    chk(sel_out_n, 1'b0, "fall not passed");
    rst = 1'b1;
    cyc(5);
    chk(sel_out_n, 1'b0, "access cut short");
    sel_in_n = 1'b1;
    cyc(1);
    chk(sel_out_n, 1'b1, "drain kept after select high");
    sel_in_n = 1'b0;
    cyc(3);
    chk(sel_out_n, 1'b1, "select leaked after drain");
    rst = 1'b0;
    cyc(4);
    rst = 1'b1;
    cyc(HOLD - 3);
    chk(sel_out_n, 1'b0, "hold ended early");
    cyc(6);
    chk(sel_out_n, 1'b1, "hold never ended");
    chk(drive_hi, 1'b1, "pull-up off after hold");
    sel_in_n = 1'b1;
    $display("test gate done");
  endtask : t_gate

  task automatic t_fault();
    int n;
    do_reset();
    wait_fall(TOUT + 10);
    chk(level_n, 1'b1, "level low with pulse");
    chk(shut_n, 1'b1, "latched on one fault");
    cyc(13);
    chk(level_n, 1'b1, "level fell early");
    cyc(1);
    chk(level_n, 1'b0, "level fell late");
    n = 14;
    while (pulse_n === 1'b0 && n < 2 * PULSE) begin
      cyc(1);
      n++;
    end
    chk(n >= PULSE && n <= PULSE + 2, 1'b1, "pulse width");
    wait_fall(TOUT + 10);
    chk(level_n, 1'b0, "level rose without strobe");
    chk(shut_n, 1'b0, "two faults not latched");
    strobe = ~strobe;
    cyc(2);
    chk(level_n, 1'b1, "strobe did not clear");
    $display("test fault done");
  endtask : t_fault

  task automatic t_kick();
    do_reset();
    repeat (6) begin
      cyc(TOUT - 10);
      strobe = ~strobe;
    end
    cyc(TOUT - 10);
    chk(seen, 1'b0, "pulse despite strobe");
    wait_fall(20);
    $display("test kick done");
  endtask : t_kick

  task automatic t_disable();
    do_reset();
    wait_fall(TOUT + 10);
    cyc(20);
    floating = 1'b1;
    cyc(2);
    chk(level_n, 1'b1, "level low while floating");
    cyc(PULSE);
    seen = 1'b0;
    cyc(3 * TOUT);
    chk(seen, 1'b0, "pulse while floating");
    floating = 1'b0;
    battery = 1'b1;
    cyc(3 * TOUT);
    chk(seen, 1'b0, "pulse in battery mode");
    chk(level_n, 1'b1, "level low in battery mode");
    battery = 1'b0;
    $display("test disable done");
  endtask : t_disable

  // capacitor select: even the smallest capacitor period far exceeds the bench default
  task automatic t_select();
    tout_sel = 1'b0;
    do_reset();
    cyc(2 * TOUT);
    chk(seen, 1'b0, "default period used with capacitor select");
    tout_sel = 1'b1;
    strobe = ~strobe;
    wait_fall(TOUT + 10);
    $display("test select done");
  endtask : t_select

  task automatic report_and_stop();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    rst = 1'b1;
    strobe = 1'b0;
    floating = 1'b0;
    battery = 1'b0;
    sel_in_n = 1'b1;
    tout_sel = 1'b1;
    seen = 1'b0;
    t_gate();
    t_fault();
    t_kick();
    t_disable();
    t_select();
    report_and_stop();
  end
endmodule : wdpcg_top_tb
`default_nettype wire
